/* File: common/reset_strap_map.svh */
`ifndef RESET_STRAP_MAP_SVH
`define RESET_STRAP_MAP_SVH

// Wishbone byte addresses (low address nibble)
`define ADDR_CTRL        4'h0
`define ADDR_STATUS      4'h4
`define ADDR_STRAPS      4'h8

// Control register fields and reset value
`define CTRL_HOST_BIT    0
`define CTRL_SOFT_BIT    1
`define CTRL_HOST_RST    1'b1

// Strap pin layout on the shared pins
`define STRAP_W          6
`define STRAP_SRC_LSB    0
`define STRAP_SRC_MSB    3
`define STRAP_DIV_BIT    4
`define STRAP_LBMUX_BIT  5

// Timing, in bus synchronisation clock periods unless noted
`define ASSERT_TICKS     512
`define NEG_GAP_TICKS    16
`define EXT_ASSERT_TICKS 32
`define FUNC_DELAY_TICKS 1
`define LOCK_TIME_US     100
`define CLK_FREQ_MHZ     40
`define LOCK_CYCLES      (`LOCK_TIME_US * `CLK_FREQ_MHZ)

`endif

/* File: common/reset_strap_pkg.sv */
package reset_strap_pkg;

  typedef enum logic [1:0] {
    ST_POR,
    ST_ASSERT,
    ST_RELEASE,
    ST_RUN
  } seq_state_t;

endpackage : reset_strap_pkg

/* File: core/input_sync3.sv */
`timescale 1ns/1ps
`default_nettype none

module input_sync3 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,   // System clock
  input  wire logic             rst_i,   // Synchronous reset
  input  wire logic [WIDTH-1:0] async_i, // Asynchronous inputs
  output logic      [WIDTH-1:0] sync_o   // Filtered, synchronised
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] agree;

  // A bit only moves once stages two and three agree
  assign agree = ~(s2_reg ^ s3_reg);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      sync_o <= '0;
    end else begin
      s1_reg <= async_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      sync_o <= (s3_reg & agree) | (sync_o & ~agree);
    end
  end

endmodule : input_sync3

`default_nettype wire

/* File: core/reset_strap_sequencer.sv */
// Decided for this implementation: the Wishbone register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "reset_strap_map.svh"

module reset_strap_sequencer #(
  parameter int ASSERT_TICKS = `ASSERT_TICKS,
  parameter int GAP_TICKS    = `NEG_GAP_TICKS,
  parameter int EXT_TICKS    = `EXT_ASSERT_TICKS,
  parameter int FUNC_TICKS   = `FUNC_DELAY_TICKS,
  parameter int LOCK_CYCLES  = `LOCK_CYCLES
) (
  input  wire logic                clk_i,                 // 40 MHz clock
  input  wire logic                rst_i,                 // Sync reset
  input  wire logic                wb_cyc_i,              // Bus cycle
  input  wire logic                wb_stb_i,              // Bus strobe
  input  wire logic                wb_we_i,               // Write enable
  input  wire logic [3:0]          wb_adr_i,              // Byte address
  input  wire logic [3:0]          wb_sel_i,              // Byte lanes
  input  wire logic [31:0]         wb_dat_i,              // Write data
  output logic      [31:0]         wb_dat_o,              // Read data
  output logic                     wb_ack_o,              // Acknowledge
  input  wire logic                power_on_reset_in_n_i, // POR pin
  input  wire logic                hard_reset_line_n_i,   // Line level
  output logic                     hard_reset_line_n_o,   // Line drive
  output logic                     hard_reset_line_oe_o,  // Line enable
  input  wire logic                pll_lock_i,            // PLL lock
  input  wire logic [`STRAP_W-1:0] strap_pins_i,          // Pin levels
  output logic      [`STRAP_W-1:0] strap_pins_o,          // Pin drive
  output logic                     strap_pins_oe_o,       // Pin enable
  input  wire logic [`STRAP_W-1:0] func_out_i,            // Function data
  output logic                     core_reset_o           // Core reset
);
  import reset_strap_pkg::*;

  localparam int SW = `STRAP_W;

  logic [SW+2:0]   sync_w;
  logic [SW-1:0]   strap_s;
  logic            por_n_s;
  logic            line_n_s;
  logic            pll_s;
  seq_state_t      state_reg;
  logic [SW-1:0]   strap_reg;
  logic            host_reg;
  logic            soft_req_reg;
  logic [1:0]      tick_cnt_reg;
  logic            tick;
  logic [9:0]      phase_cnt_reg;
  logic [4:0]      gap_cnt_reg;
  logic [5:0]      ext_cnt_reg;
  logic [11:0]     lock_cnt_reg;
  logic            lock_timeout_reg;
  logic            soft_take;
  logic            bus_req;

  // Straps are caught through the same filter, so a latched value is
  // never a metastable sample
  input_sync3 #(.WIDTH(SW + 3)) u_sync (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .async_i({pll_lock_i, hard_reset_line_n_i, power_on_reset_in_n_i,
              strap_pins_i}),
    .sync_o (sync_w)
  );

  assign strap_s  = sync_w[SW-1:0];
  assign por_n_s  = sync_w[SW];
  assign line_n_s = sync_w[SW+1];
  assign pll_s    = sync_w[SW+2];

  // Clock cycles per sync period
  function automatic logic [1:0] sync_period(input logic host,
                                             input logic div);
    sync_period = (host && div) ? 2'h2 : 2'h1;
  endfunction : sync_period

  assign tick = (tick_cnt_reg >=
                 sync_period(host_reg, strap_reg[`STRAP_DIV_BIT]) - 2'h1);

  always_ff @(posedge clk_i) begin
    if (rst_i || tick) begin
      tick_cnt_reg <= 2'h0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 2'h1;
    end
  end

  assign soft_take = (state_reg == ST_RUN) && soft_req_reg;

  // Sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg            <= ST_POR;
      strap_reg            <= '0;
      phase_cnt_reg        <= 10'h000;
      ext_cnt_reg          <= 6'h00;
      hard_reset_line_oe_o <= 1'b1;
      strap_pins_oe_o      <= 1'b0;
      core_reset_o         <= 1'b1;
    end else if (!por_n_s) begin
      state_reg            <= ST_POR;
      hard_reset_line_oe_o <= 1'b1;
      strap_pins_oe_o      <= 1'b0;
      core_reset_o         <= 1'b1;
    end else begin
      case (state_reg)
        ST_POR: begin
          strap_reg     <= strap_s;
          phase_cnt_reg <= 10'h000;
          state_reg     <= ST_ASSERT;
        end
        ST_ASSERT: begin
          if (tick && phase_cnt_reg < 10'(ASSERT_TICKS)) begin
            phase_cnt_reg <= phase_cnt_reg + 10'h001;
          end
          if (phase_cnt_reg >= 10'(ASSERT_TICKS) &&
              gap_cnt_reg >= 5'(GAP_TICKS) &&
              (pll_s || lock_timeout_reg)) begin
            hard_reset_line_oe_o <= 1'b0;
            core_reset_o         <= 1'b0;
            phase_cnt_reg        <= 10'h000;
            state_reg            <= ST_RELEASE;
          end
        end
        ST_RELEASE: begin
          if (tick && phase_cnt_reg < 10'(FUNC_TICKS)) begin
            phase_cnt_reg <= phase_cnt_reg + 10'h001;
          end
          // Wait for the line itself, so the filter lag is not taken
          // for an outside assertion
          if (tick && phase_cnt_reg + 10'h001 >= 10'(FUNC_TICKS) &&
              line_n_s) begin
            strap_pins_oe_o <= 1'b1;
            ext_cnt_reg     <= 6'h00;
            state_reg       <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (soft_take) begin
            hard_reset_line_oe_o <= 1'b1;
            strap_pins_oe_o      <= 1'b0;
            core_reset_o         <= 1'b1;
            phase_cnt_reg        <= 10'h000;
            state_reg            <= ST_ASSERT;
          end else if (!line_n_s) begin
            // Pins are released at first sight; the flow waits longer
            strap_pins_oe_o <= 1'b0;
            if (tick) begin
              ext_cnt_reg <= ext_cnt_reg + 6'h01;
            end
            if (ext_cnt_reg >= 6'(EXT_TICKS)) begin
              hard_reset_line_oe_o <= 1'b1;
              core_reset_o         <= 1'b1;
              phase_cnt_reg        <= 10'h000;
              state_reg            <= ST_ASSERT;
            end
          end else begin
            // A short glitch gives the pins back
            ext_cnt_reg     <= 6'h00;
            strap_pins_oe_o <= 1'b1;
          end
        end
        default: begin
          state_reg <= ST_POR;
        end
      endcase
    end
  end

  // Sync periods since the last negation, saturating
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gap_cnt_reg <= 5'(GAP_TICKS);
    end else if (state_reg == ST_RELEASE && phase_cnt_reg == 10'h000) begin
      gap_cnt_reg <= 5'h00;
    end else if (tick && gap_cnt_reg < 5'(GAP_TICKS)) begin
      gap_cnt_reg <= gap_cnt_reg + 5'h01;
    end
  end

  // Lock watchdog, restarted on every power-on reset
  always_ff @(posedge clk_i) begin
    if (rst_i || state_reg == ST_POR) begin
      lock_cnt_reg     <= 12'h000;
      lock_timeout_reg <= 1'b0;
    end else if (!pll_s && !lock_timeout_reg) begin
      if (lock_cnt_reg >= 12'(LOCK_CYCLES) - 12'h001) begin
        lock_timeout_reg <= 1'b1;
      end else begin
        lock_cnt_reg <= lock_cnt_reg + 12'h001;
      end
    end
  end

  // Pin data is only seen outside while the enable is high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strap_pins_o        <= '0;
      hard_reset_line_n_o <= 1'b0;
    end else begin
      strap_pins_o        <= func_out_i;
      hard_reset_line_n_o <= 1'b0;
    end
  end

  // Wishbone slave, one wait state
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      case (wb_adr_i)
        `ADDR_CTRL:   wb_dat_o <= {31'h0000_0000, host_reg};
        `ADDR_STATUS: wb_dat_o <= {24'h00_0000, lock_timeout_reg, pll_s,
                                   strap_pins_oe_o, core_reset_o,
                                   hard_reset_line_oe_o, line_n_s,
                                   state_reg};
        `ADDR_STRAPS: wb_dat_o <= {26'h000_0000, strap_reg};
        default:      wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // Soft request: a new write wins over the sequencer taking the old one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      host_reg     <= `CTRL_HOST_RST;
      soft_req_reg <= 1'b0;
    end else if (bus_req && wb_we_i && wb_sel_i[0] &&
                 wb_adr_i == `ADDR_CTRL) begin
      host_reg     <= wb_dat_i[`CTRL_HOST_BIT];
      soft_req_reg <= wb_dat_i[`CTRL_SOFT_BIT] | soft_req_reg;
    end else if (soft_take) begin
      soft_req_reg <= 1'b0;
    end
  end

endmodule : reset_strap_sequencer

`default_nettype wire

/* File: bench/reset_strap_props.sv */
`timescale 1ns/1ps
`default_nettype none
module reset_strap_props #(
  parameter int ASSERT_TICKS = 8,
  parameter int GAP_TICKS    = 4,
  parameter int FUNC_TICKS   = 1
) (
  input wire logic clk_i,                 // Clock
  input wire logic rst_i,                 // Sync reset
  input wire logic wb_cyc_i,              // Bus cycle
  input wire logic wb_stb_i,              // Bus strobe
  input wire logic wb_ack_o,              // Acknowledge
  input wire logic power_on_reset_in_n_i, // POR pin
  input wire logic hard_reset_line_oe_o,  // Line enable
  input wire logic strap_pins_oe_o,       // Pin enable
  input wire logic core_reset_o           // Core reset
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [15:0] hold_cnt, gap_cnt, rel_cnt;
  // Gap starts saturated so the first negation never looks too close
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_cnt <= 16'h0;
      gap_cnt  <= 16'hFFFF;
      rel_cnt  <= 16'h0;
    end else begin
      hold_cnt <= hard_reset_line_oe_o ? hold_cnt + 16'h1 : 16'h0;
      if ($fell(hard_reset_line_oe_o)) gap_cnt <= 16'h0;
      else if (gap_cnt != 16'hFFFF) gap_cnt <= gap_cnt + 16'h1;
      rel_cnt <= hard_reset_line_oe_o ? 16'h0 : rel_cnt + 16'h1;
    end
  end
  property p_hold; $fell(hard_reset_line_oe_o) |-> hold_cnt >= ASSERT_TICKS;
  endproperty
  a_hold: assert property (p_hold) else $error("line released early");
  property p_gap; $fell(hard_reset_line_oe_o) |-> gap_cnt >= GAP_TICKS;
  endproperty
  a_gap: assert property (p_gap) else $error("negations too close");
  property p_pins_off; hard_reset_line_oe_o |-> !strap_pins_oe_o; endproperty
  a_pins_off: assert property (p_pins_off) else $error("pins driven");
  property p_func; $rose(strap_pins_oe_o) |-> rel_cnt >= FUNC_TICKS;
  endproperty
  a_func: assert property (p_func) else $error("pins driven early");
  property p_core; hard_reset_line_oe_o |-> core_reset_o; endproperty
  a_core: assert property (p_core) else $error("core left reset");
  property p_core_rel; $fell(core_reset_o) |-> $fell(hard_reset_line_oe_o);
  endproperty
  a_core_rel: assert property (p_core_rel) else $error("core release");
  property p_lock;
    $rose(power_on_reset_in_n_i) |-> ##[1:80] !hard_reset_line_oe_o;
  endproperty
  a_lock: assert property (p_lock) else $error("flow stuck");
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("no bus answer");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  c_drive: cover property ($rose(hard_reset_line_oe_o));
  c_pins: cover property ($rose(strap_pins_oe_o));
  c_core: cover property ($fell(core_reset_o));
endmodule : reset_strap_props
bind reset_strap_sequencer reset_strap_props #(
  .ASSERT_TICKS(ASSERT_TICKS), .GAP_TICKS(GAP_TICKS),
  .FUNC_TICKS(FUNC_TICKS)
) props_i (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .power_on_reset_in_n_i(power_on_reset_in_n_i),
  .hard_reset_line_oe_o(hard_reset_line_oe_o),
  .strap_pins_oe_o(strap_pins_oe_o), .core_reset_o(core_reset_o)
);
`default_nettype wire

/* File: bench/board_model.sv */
`timescale 1ns/1ps
`default_nettype none
module board_model #(
  parameter int LOCK_DELAY = 2
) (
  input  wire logic       clk_i,      // Clock
  input  wire logic       por_cmd_i,  // Bench POR release request
  input  wire logic       pull_i,     // Board pulls line low
  input  wire logic [5:0] strap_i,    // Resistor strap levels
  input  wire logic       pll_ok_i,   // PLL may lock
  input  wire logic       line_oe_i,  // Device pulls line low
  input  wire logic       pins_oe_i,  // Device drives pins
  input  wire logic [5:0] pins_drv_i, // Device pin data
  output logic            por_n_o,    // POR pin
  output logic            line_n_o,   // Resolved line
  output logic [5:0]      pins_o,     // Resolved pins
  output logic            lock_o      // PLL lock
);
  int low_cnt = 0;
  int hi_cnt = 0;
  // Open drain with pull-up
  assign line_n_o = !(line_oe_i || pull_i);
  // Straps stay on their resistors whenever the device lets go
  assign pins_o = pins_oe_i ? pins_drv_i : strap_i;
  assign lock_o = pll_ok_i && por_n_o && hi_cnt >= LOCK_DELAY;
  always_ff @(posedge clk_i) begin
    low_cnt <= por_n_o ? 0 : low_cnt + 1;
    hi_cnt  <= por_n_o ? hi_cnt + 1 : 0;
    if (!por_cmd_i) por_n_o <= 1'b0;
    else if (low_cnt >= 32) por_n_o <= 1'b1;
  end
endmodule : board_model
`default_nettype wire

/* File: bench/reset_strap_sequencer_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module reset_strap_sequencer_bench;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, rd;
  logic        por_cmd = 0, pull = 0, pll_ok = 1, por_n, line_n, line_oe;
  logic        drv_n, pins_oe, lock, core_rst;
  logic [5:0]  straps = 6'h2A, pins, pins_drv;
  logic [5:0]  func = 6'h33;
  logic [3:0]  sel = 4'hF;
  int          num_errors = 0, comparisons = 0, n, k;
  int          held = 0;
  always #12.5 clk_i = ~clk_i;
  // Length of the device-driven run since power-on negated
  always @(posedge clk_i)
    held <= (line_oe === 1'b1 && por_n === 1'b1) ? held + 1 : 0;
  reset_strap_sequencer #(.ASSERT_TICKS(8), .GAP_TICKS(4), .EXT_TICKS(4),
    .FUNC_TICKS(1), .LOCK_CYCLES(20)) reset_strap_sequencer_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .power_on_reset_in_n_i(por_n),
    .hard_reset_line_n_i(line_n), .hard_reset_line_n_o(drv_n),
    .hard_reset_line_oe_o(line_oe), .pll_lock_i(lock),
    .strap_pins_i(pins), .strap_pins_o(pins_drv),
    .strap_pins_oe_o(pins_oe), .func_out_i(func), .core_reset_o(core_rst));
  board_model board_model_i (.clk_i(clk_i), .por_cmd_i(por_cmd),
    .pull_i(pull), .strap_i(straps), .pll_ok_i(pll_ok), .line_oe_i(line_oe),
    .pins_oe_i(pins_oe), .pins_drv_i(pins_drv), .por_n_o(por_n),
    .line_n_o(line_n), .pins_o(pins), .lock_o(lock));
  task summarize;
    $display("checks %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  task check(input string what, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d,
          input logic [3:0] s = 4'hF);
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    // No cycle limit here: only the watchdog ends a missing answer
    do begin @(posedge clk_i); end while (ack !== 1'b1);
    rd = rdat;
    cyc <= 0; stb <= 0; we <= 0;
  endtask : wb
  // Longest driven-line run seen until the shared pins go functional
  task wait_run;
    n = 0; k = 0;
    while (pins_oe !== 1'b1 && k < 300) begin
      @(posedge clk_i); k++;
      if (held > n) n = held;
    end
    check("run", k < 300, 1);
  endtask : wait_run
  task por_cycle(input logic [5:0] s, input logic ok);
    straps <= s; pll_ok <= ok; por_cmd <= 0;
    repeat (40) @(posedge clk_i);
    por_cmd <= 1;
    wait_run;
  endtask : por_cycle
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    wb(0, 4'h0, 0); check("ctrl", rd, 32'h1);
    wb(0, 4'h4, 0); check("status", rd, 32'h18);
    wb(1, 4'h8, 32'h3F);
    wb(0, 4'hC, 0); check("unmapped", rd, 32'h0);
    wb(1, 4'h0, 32'h0, 4'h0);
    wb(0, 4'h0, 0); check("lanes", rd, 32'h1);
    $display("test reset done");
    por_cycle(6'h2A, 1); check("hold", n >= 8, 1);
    wb(0, 4'h8, 0); check("straps", rd, 32'h2A);
    wb(0, 4'h4, 0); check("status", rd, 32'h67);
    check("func", pins, 6'h33);
    func <= 6'h0C;
    repeat (2) @(posedge clk_i);
    check("func", pins, 6'h0C);
    $display("test power on done");
    wb(1, 4'h0, 32'h2);
    repeat (2) @(posedge clk_i);
    check("drive", {line_n, line_oe, pins_oe, core_rst}, 4'h5);
    wb(1, 4'h0, 32'h2);
    wait_run; check("hold", n >= 8, 1);
    k = 0;
    while (line_oe !== 1'b1 && k < 20) begin @(posedge clk_i); k++; end
    check("pending", line_oe, 1);
    wait_run; check("hold", n >= 8, 1);
    $display("test soft done");
    pull <= 1;
    repeat (8) @(posedge clk_i);
    check("pins off", pins_oe, 0);
    repeat (4) @(posedge clk_i);
    pull <= 0;
    wait_run; check("hold", n >= 8, 1);
    $display("test board reset done");
    wb(1, 4'h0, 32'h1);
    por_cycle(6'h15, 1); check("divided", n >= 16, 1);
    wb(0, 4'h8, 0); check("straps", rd, 32'h15);
    por_cycle(6'h15, 0); check("timeout", n >= 20, 1);
    wb(0, 4'h4, 0); check("status", rd[7:6], 2'h2);
    $display("test host done");
    summarize;
  end
  initial begin
    #100000;
    num_errors++;
    summarize;
  end
endmodule : reset_strap_sequencer_bench
`default_nettype wire
